// ### ncss_select.sv
// Command source selector for network operation mode
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (R01) Each function takes terminal, network or combined source by class.
// (R02) Forward and reverse run follow the operation source selection.
// (R03) Output stop is combined, but terminal-only in mode 7 without interlock.
// (R04) Operation and speed source selections written while running apply only after the drive stops.
// (R05) A terminal selection equal to 67 attaches the source-switch input.
// (R06) The source-switch input only selects sources in network operation mode; it gates link resets in any mode.
// (R07) With no source-switch assigned, sources follow the two selections.
// (R08) With the switch inactive, start and speed come only from terminals.
// (R09) Source-switch changes apply only while stopped.
// (R10) With the source-switch inactive, link resets are ignored.
// (R11) The network port is picked by the communication port selection.
// (R12) Operation and speed sources are kept as two separate selections.
// (R13) Operation source encoding is 0 for network and 1 for terminals.
// (R14) With the source-switch active, sources follow the two selections.
module ncss_select
  import ncss_pkg::*;
#(
  parameter int NUM_PORTS = 2
)(
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic                   networkMode,
  input  wire logic                   driveRunning,
  input  wire logic [3:0]             operationModeSelect,
  input  wire logic [1:0]             paramWritePermission,
  input  wire logic                   operationSourceSelect,
  input  wire logic [1:0]             speedSourceSelect,
  input  wire logic [$clog2(NUM_PORTS)-1:0] commPortSourceSelect,
  input  wire logic [NCSS_NUM_TERM_SEL*8-1:0] inputTerminalFunctionSelect,
  input  wire logic                   sourceSwitchInput,
  input  wire ncss_cmd_t              termCmd,
  input  wire ncss_cmd_t [NUM_PORTS-1:0] netCmd,
  output logic                        selOpNet,
  output logic                        selSpdNet,
  output logic                        interlockActive,
  output ncss_cmd_t                   outCmd
);
  logic        switchSync1_ff, nxt_switchSync1;
  logic        switchSync2_ff, nxt_switchSync2;
  logic        opSrc_ff, nxt_opSrc;
  logic [1:0]  spdSrc_ff, nxt_spdSrc;
  logic        switchApplied_ff, nxt_switchApplied;
  ncss_state_t state_ff, nxt_state;
  ncss_cmd_t   out_ff, nxt_out;
  logic        switchAssigned, interlockAssigned, netOp, netSpd;
  logic        mode7Interlock;
  ncss_cmd_t   network_source;

  // Every check below runs on the one system clock
  default clocking cbSys @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Two stages, so a pin edge near the clock cannot reach the latch
  always_comb
  begin
    nxt_switchSync1 = sourceSwitchInput;
    nxt_switchSync2 = switchSync1_ff;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      switchSync1_ff <= 1'b0;
      switchSync2_ff <= 1'b0;
    end
    else
    begin
      switchSync1_ff <= nxt_switchSync1;
      switchSync2_ff <= nxt_switchSync2;
    end
  end

  always_comb
  begin
    switchAssigned = 1'b0;
    interlockAssigned = 1'b0;
    for (int i = 0; i < NCSS_NUM_TERM_SEL; i++)
    begin
      if (inputTerminalFunctionSelect[i*8 +: 8] == NCSS_FUNC_SRC_SWITCH)
        switchAssigned = 1'b1; // [R05]
      if (inputTerminalFunctionSelect[i*8 +: 8] == NCSS_FUNC_INTERLOCK)
        interlockAssigned = 1'b1;
    end
  end

  always_comb
  begin
    network_source = netCmd[commPortSourceSelect]; // [R11]
    nxt_state = driveRunning ? NCSS_ST_RUNNING : NCSS_ST_STOPPED;
    nxt_opSrc = opSrc_ff;
    nxt_spdSrc = spdSrc_ff;
    nxt_switchApplied = switchApplied_ff;
    case (state_ff)
      NCSS_ST_STOPPED:
      begin
        if (!driveRunning)
        begin
          // Latched only when stopped, so a live write keeps old sources
          nxt_opSrc = operationSourceSelect;  // [R04] [R12]
          nxt_spdSrc = speedSourceSelect;     // [R04] [R12]
          nxt_switchApplied = switchSync2_ff; // [R09]
        end
      end
      NCSS_ST_RUNNING:
      begin
        if (paramWritePermission != NCSS_WRITE_RUNNING)
        begin
          nxt_opSrc = opSrc_ff;
        end
      end
      default:
      begin
        nxt_state = NCSS_ST_STOPPED;
      end
    endcase
  end

  always_comb
  begin
    // In network mode an inactive switch forces terminals; otherwise the selections apply
    if (networkMode && switchAssigned && !switchApplied_ff)
    begin
      netOp = 1'b0;  // [R06] [R08]
      netSpd = 1'b0; // [R08]
    end
    else
    begin
      netOp = (opSrc_ff == NCSS_OP_NET);   // [R07] [R13] [R14]
      netSpd = (spdSrc_ff == NCSS_SPD_NET); // [R07] [R14]
    end
    mode7Interlock = (operationModeSelect == NCSS_MODE_INTERLOCK) &&
                     !interlockAssigned;
    nxt_out.fwdRun = netOp ? network_source.fwdRun : termCmd.fwdRun; // [R02] [R01]
    nxt_out.revRun = netOp ? network_source.revRun : termCmd.revRun; // [R02] [R01]
    nxt_out.speedValid = netSpd ? network_source.speedValid : termCmd.speedValid; // [R01]
    nxt_out.outputStop = mode7Interlock ? termCmd.outputStop
                         : (termCmd.outputStop | network_source.outputStop); // [R03]
    // Link resets blocked while the switch is inactive
    nxt_out.resetReq = termCmd.resetReq |
      (network_source.resetReq && !(switchAssigned && !switchApplied_ff)); // [R10]
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_ff <= NCSS_ST_STOPPED;
      opSrc_ff <= NCSS_OP_RESET;
      spdSrc_ff <= NCSS_SPD_RESET;
      switchApplied_ff <= 1'b0;
      out_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      opSrc_ff <= nxt_opSrc;
      spdSrc_ff <= nxt_spdSrc;
      switchApplied_ff <= nxt_switchApplied;
      out_ff <= nxt_out;
    end
  end

  assign outCmd = out_ff;
  assign selOpNet = netOp;
  assign selSpdNet = netSpd;
  assign interlockActive = mode7Interlock;

  // A stop is settled once the state register has seen it
  sequence stopSettled;
    !driveRunning ##1 !driveRunning;
  endsequence

  sequence runEnded;
    driveRunning ##1 stopSettled;
  endsequence

  sources_hold_a: assert property ( // [R04]
    driveRunning && $past(driveRunning) |-> $stable(opSrc_ff))
    else $error("source changed while running");
  speed_hold_a: assert property ( // [R04] [R12]
    driveRunning && $past(driveRunning) |-> $stable(spdSrc_ff))
    else $error("speed source changed while running");
  run_end_apply_a: assert property ( // [R04]
    runEnded |=> opSrc_ff == $past(operationSourceSelect) &&
                 spdSrc_ff == $past(speedSourceSelect))
    else $error("selection not applied after stop");
  switch_hold_a: assert property ( // [R09]
    $past(driveRunning) |-> $stable(switchApplied_ff))
    else $error("switch applied while running");
  switch_latch_a: assert property ( // [R09]
    stopSettled |=> switchApplied_ff == $past(switchSync2_ff))
    else $error("switch not taken while stopped");
  term_only_a: assert property ( // [R08]
    networkMode && switchAssigned && !switchApplied_ff |-> !netOp && !netSpd)
    else $error("network source with switch off");
  mode_gate_a: assert property ( // [R06]
    !networkMode |-> netOp == (opSrc_ff == NCSS_OP_NET) &&
                     netSpd == (spdSrc_ff == NCSS_SPD_NET))
    else $error("switch acted outside network mode");
  reset_block_a: assert property ( // [R10]
    switchAssigned && !switchApplied_ff && !termCmd.resetReq
    |=> !outCmd.resetReq)
    else $error("link reset passed with switch off");
  reset_pass_a: assert property ( // [R10] [R14]
    (!switchAssigned || switchApplied_ff) && network_source.resetReq
    |=> outCmd.resetReq)
    else $error("link reset lost");
  fwd_route_a: assert property ( // [R02]
    !netOp |=> outCmd.fwdRun == $past(termCmd.fwdRun))
    else $error("forward run not from terminals");
  port_pick_a: assert property ( // [R02] [R11]
    netOp |=> outCmd.revRun == $past(netCmd[commPortSourceSelect].revRun))
    else $error("reverse run not from chosen port");
  speed_route_a: assert property ( // [R01] [R08]
    !netSpd |=> outCmd.speedValid == $past(termCmd.speedValid))
    else $error("speed not from terminals");
  stop_route_a: assert property ( // [R03]
    !mode7Interlock && termCmd.outputStop |=> outCmd.outputStop)
    else $error("output stop lost");
  interlock_a: assert property ( // [R03]
    mode7Interlock && !termCmd.outputStop |=> !outCmd.outputStop)
    else $error("interlock taken from link");
  sel_follow_a: assert property ( // [R07]
    !switchAssigned |-> netOp == (opSrc_ff == NCSS_OP_NET))
    else $error("operation source not followed");
endmodule : ncss_select
`default_nettype wire

// ### ncss_pkg.sv
// Package: constants and carrier types for the command source selector
package ncss_pkg;
  localparam logic [7:0] NCSS_FUNC_OUT_STOP   = 8'h18;
  localparam logic [7:0] NCSS_FUNC_FWD        = 8'h3c;
  localparam logic [7:0] NCSS_FUNC_REV        = 8'h3d;
  localparam logic [7:0] NCSS_FUNC_SRC_SWITCH = 8'h43;
  localparam logic [7:0] NCSS_FUNC_INTERLOCK  = 8'h0c;
  localparam logic [3:0] NCSS_MODE_INTERLOCK  = 4'h7;
  localparam logic [1:0] NCSS_WRITE_RUNNING   = 2'h2;
  localparam int         NCSS_NUM_TERM_SEL    = 5;
  localparam logic       NCSS_OP_NET          = 1'b0;
  localparam logic       NCSS_OP_EXT          = 1'b1;
  localparam logic [1:0] NCSS_SPD_NET         = 2'h0;
  localparam logic [1:0] NCSS_SPD_EXT         = 2'h1;
  localparam logic [1:0] NCSS_SPD_EXT2        = 2'h2;
  localparam logic       NCSS_OP_RESET        = NCSS_OP_EXT;
  localparam logic [1:0] NCSS_SPD_RESET       = NCSS_SPD_NET;

  typedef struct packed {
    logic fwdRun;
    logic revRun;
    logic outputStop;
    logic resetReq;
    logic speedValid;
  } ncss_cmd_t;

  typedef enum logic [1:0] {
    NCSS_ST_STOPPED = 2'b01,
    NCSS_ST_RUNNING = 2'b10
  } ncss_state_t;
endpackage : ncss_pkg

// ### ncss_link_model.sv
// Link host model driving the network command ports
`timescale 1ns/1ps
`default_nettype none
module ncss_link_model
  import ncss_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            resetAll,
  output wire ncss_cmd_t [1:0] netCmd
);
  logic [9:0] count_ff = 10'h000;
  // Changes every cycle so a stale port never looks valid
  always @(negedge sys_clk)
    count_ff <= count_ff + 10'h0d5;
  assign netCmd = count_ff | (resetAll ? 10'h042 : 10'h000);
endmodule : ncss_link_model
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the command source selector
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ncss_pkg::*;
;
  typedef struct packed {ncss_cmd_t e; ncss_cmd_t m;} ncss_note_t;
  logic sys_clk = 1'b1, reset_n = 1'b0, networkMode = 1'b1;
  logic driveRunning = 1'b0, opSel = 1'b1, swIn = 1'b0, resetAll = 1'b0;
  logic [3:0] modeSel = 4'h0;
  logic [1:0] wrPerm = 2'h0, spdSel = 2'h0;
  logic portSel = 1'b0;
  logic [39:0] funcSel = 40'h0;
  ncss_cmd_t termCmd = '0, outCmd;
  ncss_cmd_t [1:0] netCmd;
  logic selOpNet, selSpdNet, interlockActive, eOp, eSpd, eBlk, eIl;
  logic [16:0] rnd = 17'h17fb5;
  int errors = 0, comparisons = 0;
  ncss_note_t q[$];
  ncss_note_t nt;
  ncss_select #(.NUM_PORTS(2)) dut (.sys_clk, .reset_n, .networkMode,
    .driveRunning, .operationModeSelect(modeSel),
    .paramWritePermission(wrPerm), .operationSourceSelect(opSel),
    .speedSourceSelect(spdSel), .commPortSourceSelect(portSel),
    .inputTerminalFunctionSelect(funcSel), .sourceSwitchInput(swIn),
    .termCmd, .netCmd, .selOpNet, .selSpdNet, .interlockActive, .outCmd);
  ncss_link_model host (.sys_clk, .resetAll, .netCmd);
  initial forever #4 sys_clk = ~sys_clk;
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction : lfsr
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic cmp_bit(input string s, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s exp %b seen %b", s, e, g);
    end
  endtask : cmp_bit
  // Masked compare, so a field with an unsettled source can be left out
  task automatic cmp_cmd(input ncss_note_t n);
    comparisons++;
    if ((outCmd & n.m) !== (n.e & n.m))
    begin
      errors++;
      $display("wrong value outCmd exp %h seen %h", n.e & n.m, outCmd & n.m);
    end
  endtask : cmp_cmd
  always @(posedge sys_clk)
  begin
    #1;
    if (q.size() > 0)
    begin
      nt = q.pop_front();
      cmp_cmd(nt);
    end
  end
  task automatic chk(input int n);
    ncss_note_t x;
    repeat (n) @(negedge sys_clk);
    rnd = lfsr(rnd);
    termCmd = rnd[4:0];
    #1;
    x.e = termCmd;
    x.m = 5'h1f;
    x.e.resetReq = termCmd.resetReq | (!eBlk & netCmd[portSel].resetReq);
    if (eOp)
      {x.e.fwdRun, x.e.revRun} = {netCmd[portSel][4], netCmd[portSel][3]};
    if (eSpd)
      x.e.speedValid = netCmd[portSel].speedValid;
    x.e.outputStop = termCmd.outputStop | (!eIl & netCmd[portSel][2]);
    q.push_back(x);
    @(negedge sys_clk);
  endtask : chk
  initial
  begin
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    cmp_bit("selOpNet", 1'b0, selOpNet);
    {eBlk, eIl} = 2'b00;
    for (int i = 0; i < 12; i++)
    begin
      {spdSel, opSel, portSel} = i[3:0];
      eOp = !i[1];
      eSpd = (i[3:2] == 2'h0);
      chk(2);
      cmp_bit("selOpNet", eOp, selOpNet);
      cmp_bit("selSpdNet", eSpd, selSpdNet);
    end
    $display("source table test done");
    opSel = 1'b0;
    eOp = 1'b1;
    chk(2);
    driveRunning = 1'b1;
    wrPerm = NCSS_WRITE_RUNNING;
    opSel = 1'b1;
    chk(3);
    driveRunning = 1'b0;
    eOp = 1'b0;
    chk(2);
    $display("write while running test done");
    for (int k = 0; k < 5; k++)
    begin
      funcSel = 40'h43 << (8 * k);
      {opSel, spdSel, swIn, resetAll} = 5'b00001;
      {eOp, eSpd, eBlk} = 3'b001;
      chk(6);
      swIn = 1'b1;
      {eOp, eSpd, eBlk} = 3'b110;
      chk(6);
      driveRunning = 1'b1;
      swIn = 1'b0;
      chk(6);
      driveRunning = 1'b0;
      {eOp, eSpd, eBlk} = 3'b001;
      chk(6);
    end
    {networkMode, eOp, eSpd, eBlk} = 4'b0111;
    chk(2);
    cmp_bit("selSpdNet", 1'b1, selSpdNet);
    networkMode = 1'b1;
    $display("source switch test done");
    {funcSel, resetAll, eBlk, opSel, spdSel} = {40'h0, 5'b00110};
    modeSel = NCSS_MODE_INTERLOCK;
    {eOp, eSpd, eIl} = 3'b001;
    chk(2);
    cmp_bit("interlockActive", 1'b1, interlockActive);
    funcSel = 40'h0c;
    eIl = 1'b0;
    chk(2);
    cmp_bit("interlockActive", 1'b0, interlockActive);
    $display("interlock test done");
    tally_and_finish;
  end
  initial
  begin
    #40000;
    errors++;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
